/* File: pkg/pma_type_pkg.sv */
// Behaviour
// R1: The registers sit in device 0x01 at addresses 0x0005, 0x0006, 0x0007.
// R2: The lower presence register is read-only and always returns 0x008B.
// R3: The upper presence register is read-only and always returns 0xC000.
// R4: Bits [6:0] are a read/write type select, reset 0x3D; [15:7] are zero.
// R5: The select applies only with autonegotiation off and forced link on.
// R6: With autonegotiation on, its outcome gives the type, not the select.
// R7: Software writes only the single-pair BASE-T1 code into the type select.
// R8: Writes to presence registers and reserved control bits have no effect.
package pma_type_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [4:0]  MMD_PMA_PMD        = 5'h01;
    localparam logic [15:0] ADDR_PRESENCE_LOW  = 16'h0005;
    localparam logic [15:0] ADDR_PRESENCE_HIGH = 16'h0006;
    localparam logic [15:0] ADDR_MEDIUM_CTRL   = 16'h0007;

    // ****************************************************************
    // Fixed and reset values
    // ****************************************************************
    localparam logic [15:0] PRESENCE_LOW_VALUE  = 16'h008B;
    localparam logic [15:0] PRESENCE_HIGH_VALUE = 16'hC000;
    localparam int          TYPE_SEL_LSB        = 0;
    localparam int          TYPE_SEL_MSB        = 6;
    localparam int          TYPE_SEL_WIDTH      = 7;
    localparam logic [6:0]  TYPE_SEL_RESET      = 7'h3D;
    localparam logic [6:0]  TYPE_BASE_T1        = 7'h3D;
    localparam logic [15:0] READ_UNMAPPED       = 16'h0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0]
    {
        SRC_NONE   = 2'b00,
        SRC_AUTONEG = 2'b01,
        SRC_FORCED = 2'b10
    } type_source_t;

    typedef struct packed
    {
        logic        rd;
        logic        wr;
        logic [4:0]  mmd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef struct packed
    {
        logic        valid;
        logic        hit;
        logic [15:0] rdata;
    } mgmt_rsp_t;

endpackage

/* File: src/medium_type_resolve.sv */
`timescale 1ns/100ps

// ********************************************************************
// Chooses where the active PHY medium type comes from
// ********************************************************************
module medium_type_resolve
    import pma_type_pkg::*;
(
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    // Mode inputs
    input  wire logic                      an_enable,
    input  wire logic                      forced_link_en,
    // Type candidates
    input  wire logic [TYPE_SEL_WIDTH-1:0] medium_type_select,
    input  wire logic [TYPE_SEL_WIDTH-1:0] an_resolved_type,
    input  wire logic                      an_resolved_valid,
    // Result
    output logic [TYPE_SEL_WIDTH-1:0]      active_type_ff,
    output logic                           active_valid_ff,
    output type_source_t                   active_source_ff
);

    type_source_t              nxt_source;
    logic [TYPE_SEL_WIDTH-1:0] nxt_type;
    logic                      nxt_valid;

    // ****************************************************************
    // Source selection
    // ****************************************************************
    always_comb
    begin
        nxt_source = SRC_NONE;
        nxt_type   = active_type_ff;
        nxt_valid  = 1'b0;
        if (an_enable)
        begin
            nxt_source = SRC_AUTONEG;             // see R6
            nxt_type   = an_resolved_type;        // see R6
            nxt_valid  = an_resolved_valid;
        end
        else if (forced_link_en)
        begin
            nxt_source = SRC_FORCED;              // see R5
            nxt_type   = medium_type_select;      // see R5
            nxt_valid  = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            active_type_ff   <= TYPE_SEL_RESET;
            active_valid_ff  <= 1'b0;
            active_source_ff <= SRC_NONE;
        end
        else
        begin
            active_type_ff   <= nxt_type;
            active_valid_ff  <= nxt_valid;
            active_source_ff <= nxt_source;
        end
    end

endmodule

/* File: src/pma_pmd_ident_type_regs.sv */
`timescale 1ns/100ps

// ********************************************************************
// Presence and medium type registers of the PMA/PMD management device
// ********************************************************************
module pma_pmd_ident_type_regs
    import pma_type_pkg::*;
(
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst,
    // Management register port
    input  wire mgmt_req_t                 mgmt_req,
    output mgmt_rsp_t                      mgmt_rsp,
    // Link configuration state
    input  wire logic                      an_enable,
    input  wire logic                      forced_link_en,
    input  wire logic [TYPE_SEL_WIDTH-1:0] an_resolved_type,
    input  wire logic                      an_resolved_valid,
    // Medium type outputs
    output logic [TYPE_SEL_WIDTH-1:0]      medium_type_select,
    output logic [TYPE_SEL_WIDTH-1:0]      active_medium_type,
    output logic                           active_type_valid,
    output type_source_t                   active_type_source,
    output logic                           type_select_invalid
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic is_reg(input mgmt_req_t req,
                                    input logic [15:0] addr);
        is_reg = (req.mmd == MMD_PMA_PMD) && (req.addr == addr);
    endfunction

    logic                      sel_low;
    logic                      sel_high;
    logic                      sel_ctrl;
    logic [TYPE_SEL_WIDTH-1:0] type_select_ff;
    logic [TYPE_SEL_WIDTH-1:0] nxt_type_select;
    logic                      invalid_ff;
    mgmt_rsp_t                 rsp_ff;
    mgmt_rsp_t                 nxt_rsp;

    assign sel_low  = is_reg(mgmt_req, ADDR_PRESENCE_LOW);  // see R1
    assign sel_high = is_reg(mgmt_req, ADDR_PRESENCE_HIGH); // see R1
    assign sel_ctrl = is_reg(mgmt_req, ADDR_MEDIUM_CTRL);   // see R1

    // ****************************************************************
    // Type select field
    // ****************************************************************
    always_comb
    begin
        nxt_type_select = type_select_ff;
        if (mgmt_req.wr && sel_ctrl)
        begin
            // Only the low field is stored; upper bits are dropped.
            nxt_type_select =
                mgmt_req.wdata[TYPE_SEL_MSB:TYPE_SEL_LSB];  // see R4, R8
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            type_select_ff <= TYPE_SEL_RESET;               // see R4
        end
        else
        begin
            type_select_ff <= nxt_type_select;
        end
    end

    // ****************************************************************
    // Flag a type code other than single-pair BASE-T1
    // ****************************************************************
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            invalid_ff <= 1'b0;
        end
        else
        begin
            invalid_ff <= (nxt_type_select != TYPE_BASE_T1); // see R7
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb
    begin
        nxt_rsp       = '0;
        nxt_rsp.valid = mgmt_req.rd;
        nxt_rsp.rdata = READ_UNMAPPED;
        if (mgmt_req.rd)
        begin
            nxt_rsp.hit = sel_low || sel_high || sel_ctrl;
            if (sel_low)
            begin
                nxt_rsp.rdata = PRESENCE_LOW_VALUE;          // see R2, R8
            end
            else if (sel_high)
            begin
                nxt_rsp.rdata = PRESENCE_HIGH_VALUE;         // see R3, R8
            end
            else if (sel_ctrl)
            begin
                nxt_rsp.rdata = {9'h000, type_select_ff};    // see R4
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rsp_ff <= '0;
        end
        else
        begin
            rsp_ff <= nxt_rsp;
        end
    end

    assign mgmt_rsp            = rsp_ff;
    assign medium_type_select  = type_select_ff;
    assign type_select_invalid = invalid_ff;

    // ****************************************************************
    // Active medium type
    // ****************************************************************
    medium_type_resolve u_resolve
    (
        .clock              (clock),
        .rst                (rst),
        .an_enable          (an_enable),
        .forced_link_en     (forced_link_en),
        .medium_type_select (type_select_ff),
        .an_resolved_type   (an_resolved_type),
        .an_resolved_valid  (an_resolved_valid),
        .active_type_ff     (active_medium_type),
        .active_valid_ff    (active_type_valid),
        .active_source_ff   (active_type_source)
    );

endmodule

/* File: sim/pma_regs_chk.sv */
`timescale 1ns/100ps
// ****
// Checks on the register port and the type resolve path.
// ****
module pma_regs_chk
    import pma_type_pkg::*;
(
    // Clock and reset
    input wire logic         clock,
    input wire logic         rst,
    // Register port
    input wire mgmt_req_t    mgmt_req,
    input wire mgmt_rsp_t    mgmt_rsp,
    // Modes and types
    input wire logic         an_enable,
    input wire logic         forced_link_en,
    input wire logic [6:0]   an_resolved_type,
    input wire logic         an_resolved_valid,
    input wire logic [6:0]   medium_type_select,
    input wire logic [6:0]   active_medium_type,
    input wire logic         active_type_valid,
    input wire type_source_t active_type_source,
    input wire logic         type_select_invalid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire        on_mmd = mgmt_req.mmd == MMD_PMA_PMD;
    wire [15:0] ad     = mgmt_req.addr;
    wire        mapped = on_mmd && ad >= 16'h0005 && ad <= 16'h0007;
    wire        rd_ok  = mgmt_req.rd && on_mmd;
    a_read_answer: assert property (mgmt_req.rd |=> mgmt_rsp.valid
        && mgmt_rsp.hit == $past(mapped)) else $error("read answer wrong");
    a_no_stray: assert property (!mgmt_req.rd |=> !mgmt_rsp.valid)
        else $error("answer without read");
    a_unmapped_read: assert property (mgmt_req.rd && !mapped |=>
        !mgmt_rsp.hit && mgmt_rsp.rdata == 16'h0000) else $error("unmapped");
    a_low_word: assert property (
        rd_ok && ad == ADDR_PRESENCE_LOW |=> mgmt_rsp.rdata == 16'h008B)
        else $error("low presence word wrong");
    a_high_word: assert property (
        rd_ok && ad == ADDR_PRESENCE_HIGH |=> mgmt_rsp.rdata == 16'hC000)
        else $error("high presence word wrong");
    a_ctrl_read: assert property (
        rd_ok && ad == ADDR_MEDIUM_CTRL |=>
        mgmt_rsp.rdata == {9'h000, $past(medium_type_select)})
        else $error("control word read wrong");
    a_select_store: assert property (mgmt_req.wr && on_mmd
        && ad == ADDR_MEDIUM_CTRL |=> medium_type_select
        == $past(mgmt_req.wdata[6:0])) else $error("select not stored");
    a_forced_type: assert property (!an_enable && forced_link_en |=>
        active_type_source == SRC_FORCED && active_type_valid
        && active_medium_type == $past(medium_type_select))
        else $error("forced type wrong");
    a_autoneg_type: assert property (an_enable |=>
        active_type_source == SRC_AUTONEG
        && active_type_valid == $past(an_resolved_valid)
        && (!$past(an_resolved_valid)
        || active_medium_type == $past(an_resolved_type)))
        else $error("autoneg type wrong");
    a_idle_hold: assert property (!an_enable && !forced_link_en |=>
        active_type_source == SRC_NONE && !active_type_valid
        && $stable(active_medium_type)) else $error("idle type moved");
    a_invalid_flag: assert property (type_select_invalid
        == (medium_type_select != TYPE_BASE_T1)) else $error("flag wrong");
    cover property (mgmt_req.wr && on_mmd && ad == ADDR_MEDIUM_CTRL);
    cover property (!an_enable && forced_link_en);
    cover property (an_enable && forced_link_en);
    cover property (mgmt_req.rd && !mapped);
endmodule

/* File: sim/tb.sv */
`timescale 1ns/100ps
// ****
// Bench for the presence and medium type registers.
// ****
module tb
    import pma_type_pkg::*;
;
    typedef struct packed
    {
        logic [4:0]  m;
        logic [15:0] a;
        logic        h;
        logic [15:0] d;
    } row_t;
    logic         clock = 1'b0;
    logic         rst = 1'b1;
    mgmt_req_t    mgmt_req = '0;
    mgmt_rsp_t    mgmt_rsp;
    logic         an_enable = 1'b0;
    logic         forced_link_en = 1'b0;
    logic [6:0]   an_resolved_type = 7'h00;
    logic         an_resolved_valid = 1'b0;
    logic [6:0]   sel;
    logic [6:0]   act;
    logic         act_v;
    type_source_t src;
    logic         inv;
    int           miscompares = 0;
    int           check_count = 0;
    int           cyc = 0;
    row_t rows [6] = '{'{5'h01, 16'h0005, 1'b1, 16'h008B},
        '{5'h01, 16'h0006, 1'b1, 16'hC000}, '{5'h01, 16'h0007, 1'b1, 16'h003D},
        '{5'h01, 16'h0008, 1'b0, 16'h0000}, '{5'h02, 16'h0005, 1'b0, 16'h0000},
        '{5'h01, 16'h0004, 1'b0, 16'h0000}};
    always #25 clock = ~clock;
    pma_pmd_ident_type_regs i_pma_pmd_ident_type_regs (.clock(clock),
        .rst(rst), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
        .an_enable(an_enable), .forced_link_en(forced_link_en),
        .an_resolved_type(an_resolved_type),
        .an_resolved_valid(an_resolved_valid), .medium_type_select(sel),
        .active_medium_type(act), .active_type_valid(act_v),
        .active_type_source(src), .type_select_invalid(inv));
    task give_verdict();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock) mgmt_req <= '{1'b0, 1'b1, 5'h01, a, d};
        @(posedge clock) mgmt_req <= '0;
        #1;
    endtask
    task rchk(input logic [4:0] m, input logic [15:0] a, input logic h,
              input logic [15:0] e);
        @(posedge clock) mgmt_req <= '{1'b1, 1'b0, m, a, 16'h0000};
        @(posedge clock) mgmt_req <= '0;
        #1;
        chk({15'h0000, mgmt_rsp.valid}, 16'h0001);
        chk({15'h0000, mgmt_rsp.hit}, {15'h0000, h});
        chk(mgmt_rsp.rdata, e);
    endtask
    task mode(input logic a, input logic f, input logic v, input logic [1:0] s,
              input logic [6:0] t, input logic ev);
        @(posedge clock)
        begin
            an_enable <= a;
            forced_link_en <= f;
            an_resolved_type <= 7'h15;
            an_resolved_valid <= v;
        end
        repeat (2) @(posedge clock);
        #1;
        chk({14'h0000, src}, {14'h0000, s});
        chk({15'h0000, act_v}, {15'h0000, ev});
        chk({9'h000, act}, {9'h000, t});
    endtask
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        chk({9'h000, sel}, 16'h003D);
        foreach (rows[i])
            rchk(rows[i].m, rows[i].a,
                 rows[i].h, rows[i].d);
        wr(16'h0005, 16'hFFFF);
        wr(16'h0006, 16'hFFFF);
        wr(16'h0007, 16'hFFAA);
        chk({9'h000, sel}, 16'h002A);
        chk({15'h0000, inv}, 16'h0001);
        rchk(5'h01, 16'h0005, 1'b1, 16'h008B);
        rchk(5'h01, 16'h0006, 1'b1, 16'hC000);
        rchk(5'h01, 16'h0007, 1'b1, 16'h002A);
        mode(1'b0, 1'b1, 1'b0, 2'b10, 7'h2A, 1'b1);
        mode(1'b1, 1'b1, 1'b1, 2'b01, 7'h15, 1'b1);
        mode(1'b1, 1'b0, 1'b0, 2'b01, 7'h15, 1'b0);
        mode(1'b0, 1'b0, 1'b0, 2'b00, 7'h15, 1'b0);
        wr(16'h0007, {9'h000, TYPE_BASE_T1});
        chk({15'h0000, inv}, 16'h0000);
        wr(16'h0007, 16'h0011);
        chk({15'h0000, inv}, 16'h0001);
        @(posedge clock) rst <= 1'b1;
        @(posedge clock) rst <= 1'b0;
        #1;
        chk({9'h000, sel}, 16'h003D);
        chk({15'h0000, inv}, 16'h0000);
        chk({15'h0000, act_v}, 16'h0000);
        chk({14'h0000, src}, 16'h0000);
        rchk(5'h01, 16'h0007, 1'b1, 16'h003D);
        give_verdict();
    end
endmodule
bind pma_pmd_ident_type_regs pma_regs_chk i_pma_regs_chk (.clock(clock),
    .rst(rst), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
    .an_enable(an_enable), .forced_link_en(forced_link_en),
    .an_resolved_type(an_resolved_type),
    .an_resolved_valid(an_resolved_valid),
    .medium_type_select(medium_type_select),
    .active_medium_type(active_medium_type),
    .active_type_valid(active_type_valid),
    .active_type_source(active_type_source),
    .type_select_invalid(type_select_invalid));
